//--- bpss_sequencer.sv
/*
  Belt print scan sequencer: follows the moving type belt from its transducer
  pulses, walks subscans, odd and even print scans of one print line, compares
  requested against aligned characters and gang-fires buffered hammers.
  Assumes a subscan lasts well over 16 clk_sys cycles and that the image is
  loaded while no line is in progress.
*/
`timescale 1ns/100ps

module bpss_sequencer #(
  parameter int unsigned MAX_FIRE = bpss_pkg::MAX_FIRE,
  parameter int unsigned DUMMY_SS = bpss_pkg::DUMMY_SS
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        clk_en,
  input  wire logic        timing_mark,
  input  wire logic        home_mark,
  input  wire logic [1:0]  charset_sel,
  input  wire logic        start_line,
  input  wire logic        img_we,
  input  wire logic [7:0]  img_addr,
  input  wire logic [6:0]  img_char,
  input  wire logic        img_print,
  output logic      [65:0] hammer_fire_q,
  output logic             line_busy_q,
  output logic             line_done_q,
  output logic             belt_synced_q,
  output logic             sync_err_q
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [6:0] set_size(input logic [1:0] sel);
    logic [6:0] n;
    n = bpss_pkg::N_48;
    if (sel == bpss_pkg::SET_64) begin
      n = bpss_pkg::N_64;
    end else if (sel == bpss_pkg::SET_96) begin
      n = bpss_pkg::N_96;
    end
    return n;
  endfunction

  // Zero-based print position examined at step k of a subscan.
  function automatic logic [7:0] pos_of(input logic [2:0] ss,
                                        input logic       par,
                                        input logic [3:0] k);
    logic [7:0] p;
    p = {4'h0, ss, 1'b0} + {7'h00, par} + 8'(k * bpss_pkg::POS_STEP);
    return p;
  endfunction

  // Belt character aligned at that position, modulo the set size.
  function automatic logic [6:0] char_at(input logic [6:0] base,
                                         input logic [2:0] ss,
                                         input logic [3:0] k,
                                         input logic [6:0] n);
    logic [7:0] s;
    s = {1'b0, base} + {5'h00, ss} + 8'(k * bpss_pkg::BELT_STEP);
    if (s >= {1'b0, n}) begin
      s = s - {1'b0, n};
    end
    if (s >= {1'b0, n}) begin
      s = s - {1'b0, n};
    end
    return s[6:0];
  endfunction

  logic [6:0] n_chars;
  assign n_chars = set_size(charset_sel);

  // ---------------------------------------------------------------
  // Transducer inputs: three-stage synchronisers and filters
  // ---------------------------------------------------------------
  logic [2:0] mark_s_q, mark_s_d, home_s_q, home_s_d;
  logic       mark_f_q, mark_f_d, home_f_q, home_f_d;
  logic       tick_q, tick_d, home_edge_q, home_edge_d;

  always_comb begin
    mark_s_d    = {mark_s_q[1:0], timing_mark};
    home_s_d    = {home_s_q[1:0], home_mark};
    mark_f_d    = (mark_s_q[1] == mark_s_q[2]) ? mark_s_q[2] : mark_f_q;
    home_f_d    = (home_s_q[1] == home_s_q[2]) ? home_s_q[2] : home_f_q;
    // Both edges of a mark give a subscan pulse.
    tick_d      = mark_f_d != mark_f_q;
    home_edge_d = home_f_d & ~home_f_q;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mark_s_q    <= 3'h0;
      home_s_q    <= 3'h0;
      mark_f_q    <= 1'b0;
      home_f_q    <= 1'b0;
      tick_q      <= 1'b0;
      home_edge_q <= 1'b0;
    end else if (clk_en) begin
      mark_s_q    <= mark_s_d;
      home_s_q    <= home_s_d;
      mark_f_q    <= mark_f_d;
      home_f_q    <= home_f_d;
      tick_q      <= tick_d;
      home_edge_q <= home_edge_d;
    end
  end

  // ---------------------------------------------------------------
  // Belt tracking
  // ---------------------------------------------------------------
  logic [2:0] ss_q, ss_d, ss_nx;
  logic [6:0] belt_q, belt_d, belt_nx;
  logic       synced_d, err_d;

  always_comb begin
    ss_nx = (ss_q == bpss_pkg::SS_LAST) ? bpss_pkg::SS_FIRST : ss_q + 3'h1;
    belt_nx = belt_q;
    if (ss_q == bpss_pkg::SS_LAST) begin
      // Wrap after the last character of the set.
      belt_nx = (belt_q >= n_chars - 7'h01) ? 7'h00 : belt_q + 7'h01;
    end
    ss_d     = ss_q;
    belt_d   = belt_q;
    synced_d = belt_synced_q;
    err_d    = sync_err_q & ~start_line;
    // Home wins over a coincident subscan pulse; before sync it phases the count, once synced it is only checked.
    if (home_edge_q) begin
      if (!belt_synced_q) begin
        // Home sits one subscan ahead of the first character.
        synced_d = 1'b1;
        ss_d     = bpss_pkg::SS_LAST;
        belt_d   = n_chars - 7'h01;
      end else if (ss_q != bpss_pkg::SS_LAST ||
                   belt_q != n_chars - 7'h01) begin
        err_d = 1'b1;
      end
    end else if (tick_q) begin
      ss_d   = ss_nx;
      belt_d = belt_nx;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ss_q          <= 3'h0;
      belt_q        <= 7'h00;
      belt_synced_q <= 1'b0;
      sync_err_q    <= 1'b0;
    end else if (clk_en) begin
      ss_q          <= ss_d;
      belt_q        <= belt_d;
      belt_synced_q <= synced_d;
      sync_err_q    <= err_d;
    end
  end

  // ---------------------------------------------------------------
  // Print image and option walk
  // ---------------------------------------------------------------
  bpss_pkg::bpss_state_t state_q, state_d;
  logic [131:0] req_q, req_d, printed_q, printed_d, hit_q, hit_d;
  logic [6:0]   scan_q, scan_d, cnt_q, cnt_d;
  logic [4:0]   dcnt_q, dcnt_d;
  logic [2:0]   nhit_q, nhit_d, wss_q, wss_d;
  logic [3:0]   k_q, k_d;
  logic         walk_q, walk_d, par_q, par_d, cmp_v_q, cmp_v_d;
  logic [7:0]   cmp_pos_q, cmp_pos_d, rd_addr;
  logic [6:0]   cmp_chr_q, cmp_chr_d, rd_char;
  logic         restart_q, restart_d, pend_q, pend_d;
  logic [65:0]  fire_d;
  logic         busy_d, done_d, ovf, pend, hit;

  assign rd_addr = pos_of(wss_q, par_q, k_q);

  bpss_img_mem #(
    .WIDTH (bpss_pkg::CHAR_W),
    .DEPTH (bpss_pkg::NUM_POS),
    .AW    (bpss_pkg::POS_W)
  ) u_img (
    .clk_sys   (clk_sys),
    .clk_en    (clk_en),
    .wr_en     (img_we && state_q == bpss_pkg::BPSS_IDLE),
    .wr_addr   (img_addr),
    .wr_data   (img_char),
    .rd_addr   (rd_addr),
    .rd_data_q (rd_char)
  );

  // ---------------------------------------------------------------
  // Line sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    req_d     = req_q;
    printed_d = printed_q;
    hit_d     = hit_q;
    scan_d    = scan_q;
    cnt_d     = cnt_q;
    dcnt_d    = dcnt_q;
    nhit_d    = nhit_q;
    wss_d     = wss_q;
    par_d     = par_q;
    k_d       = k_q;
    walk_d    = walk_q;
    restart_d = restart_q;
    pend_d    = pend_q | start_line;
    fire_d    = hammer_fire_q;
    done_d    = 1'b0;
    ovf       = nhit_q > 3'(MAX_FIRE);
    pend      = 1'b0;
    // Issue one read per cycle; compare a cycle later.
    cmp_v_d   = walk_q;
    cmp_pos_d = rd_addr;
    cmp_chr_d = char_at(scan_q, wss_q, k_q, n_chars);
    if (walk_q) begin
      // Subscan one takes a fourteenth step to reach 131 or 132.
      walk_d = k_q != ((wss_q == bpss_pkg::SS_FIRST) ?
                       bpss_pkg::K_LAST + 4'h1 : bpss_pkg::K_LAST);
      k_d    = k_q + 4'h1;
    end
    if (img_we && state_q == bpss_pkg::BPSS_IDLE &&
        img_addr < 8'(bpss_pkg::NUM_POS)) begin
      req_d[img_addr] = img_print;
    end
    // Only unprinted, requested places can match.
    hit = cmp_v_q && req_q[cmp_pos_q] && !printed_q[cmp_pos_q] &&
          rd_char == cmp_chr_q;
    if (hit) begin
      hit_d[cmp_pos_q] = 1'b1;
      nhit_d = ovf ? nhit_q : nhit_q + 3'h1;
    end
    if (tick_q && !home_edge_q) begin
      // Gang-fire last subscan's buffer; hammer h serves 2h and 2h+1.
      for (int h = 0; h < bpss_pkg::NUM_HAM; h++) begin
        fire_d[h] = !ovf && (hit_q[2*h] || hit_q[2*h+1]);
      end
      if (!ovf) begin
        printed_d = printed_q | hit_q;
      end else begin
        restart_d = 1'b1;
      end
      hit_d  = '0;
      nhit_d = 3'h0;
      pend   = |(req_q & ~printed_d &
                 (par_q ? ~bpss_pkg::ODD_MASK : bpss_pkg::ODD_MASK));
      unique case (state_q)
        bpss_pkg::BPSS_IDLE: begin
          if (pend_q && belt_synced_q && ss_nx == bpss_pkg::SS_FIRST) begin
            state_d   = bpss_pkg::BPSS_ODD;
            printed_d = '0;
            pend_d    = 1'b0;
            restart_d = 1'b0;
            cnt_d     = 7'h00;
            par_d     = 1'b0;
          end
        end
        bpss_pkg::BPSS_ODD, bpss_pkg::BPSS_EVEN: begin
          if (ss_nx == bpss_pkg::SS_FIRST) begin
            cnt_d = cnt_q + 7'h01;
            if (restart_q || ovf) begin
              cnt_d     = 7'h00;
              restart_d = 1'b0;
            end else if (cnt_q == n_chars - 7'h01 || !pend) begin
              // Phase over, or nothing left of this parity.
              state_d = (state_q == bpss_pkg::BPSS_ODD) ?
                        bpss_pkg::BPSS_DUMMY : bpss_pkg::BPSS_EXTRA;
              dcnt_d  = 5'h00;
              cnt_d   = 7'h00;
            end
          end
        end
        bpss_pkg::BPSS_DUMMY: begin
          dcnt_d = (dcnt_q == 5'h1f) ? dcnt_q : dcnt_q + 5'h01;
          // Settle for the dummy subscans, then wait for a scan boundary.
          if (dcnt_d >= 5'(DUMMY_SS) &&
              ss_nx == bpss_pkg::SS_FIRST) begin
            state_d   = bpss_pkg::BPSS_EVEN;
            restart_d = 1'b0;
            par_d     = 1'b1;
          end
        end
        bpss_pkg::BPSS_EXTRA: begin
          // The extra scan only fires what the last subscan chose.
          if (ss_nx == bpss_pkg::SS_FIRST) begin
            state_d = bpss_pkg::BPSS_IDLE;
            done_d  = 1'b1;
          end
        end
        default: begin
          state_d = bpss_pkg::BPSS_IDLE;
        end
      endcase
      if (state_d == bpss_pkg::BPSS_ODD || state_d == bpss_pkg::BPSS_EVEN) begin
        if (ss_nx == bpss_pkg::SS_FIRST) begin
          scan_d = belt_nx;
        end
        // Start positions 2*ss plus parity, then steps of ten.
        walk_d = 1'b1;
        k_d    = 4'h0;
        wss_d  = ss_nx;
      end
    end
    busy_d = state_d != bpss_pkg::BPSS_IDLE;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_q       <= bpss_pkg::BPSS_IDLE;
      req_q         <= '0;
      printed_q     <= '0;
      hit_q         <= '0;
      scan_q        <= 7'h00;
      cnt_q         <= 7'h00;
      dcnt_q        <= 5'h00;
      nhit_q        <= 3'h0;
      wss_q         <= 3'h0;
      par_q         <= 1'b0;
      k_q           <= 4'h0;
      walk_q        <= 1'b0;
      cmp_v_q       <= 1'b0;
      cmp_pos_q     <= 8'h00;
      cmp_chr_q     <= 7'h00;
      restart_q     <= 1'b0;
      pend_q        <= 1'b0;
      hammer_fire_q <= '0;
      line_busy_q   <= 1'b0;
      line_done_q   <= 1'b0;
    end else if (clk_en) begin
      state_q       <= state_d;
      req_q         <= req_d;
      printed_q     <= printed_d;
      hit_q         <= hit_d;
      scan_q        <= scan_d;
      cnt_q         <= cnt_d;
      dcnt_q        <= dcnt_d;
      nhit_q        <= nhit_d;
      wss_q         <= wss_d;
      par_q         <= par_d;
      k_q           <= k_d;
      walk_q        <= walk_d;
      cmp_v_q       <= cmp_v_d;
      cmp_pos_q     <= cmp_pos_d;
      cmp_chr_q     <= cmp_chr_d;
      restart_q     <= restart_d;
      pend_q        <= pend_d;
      hammer_fire_q <= fire_d;
      line_busy_q   <= busy_d;
      line_done_q   <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_fire_limit:
    assert property ($countones(hammer_fire_q) <= MAX_FIRE)
    else $error("more hammers fired than allowed");
  a_fire_buffer:
    assert property (clk_en && tick_q && !home_edge_q && !ovf |=>
                     hammer_fire_q[0] == ($past(hit_q[0]) | $past(hit_q[1])))
    else $error("hammer fire does not follow buffer");
  a_scan_load:
    assert property (clk_en && tick_q && !home_edge_q &&
                     ss_q == bpss_pkg::SS_LAST &&
                     state_d == bpss_pkg::BPSS_ODD |=> scan_q == belt_q)
    else $error("scan register not loaded from belt counter");
  a_belt_wrap:
    assert property (clk_en && tick_q && !home_edge_q &&
                     ss_q == bpss_pkg::SS_LAST &&
                     belt_q == n_chars - 7'h01 |=> belt_q == 7'h00)
    else $error("belt counter did not wrap");
  a_home_check:
    assert property (clk_en && home_edge_q && belt_synced_q &&
                     ss_q != bpss_pkg::SS_LAST |=> sync_err_q)
    else $error("misplaced home pulse not flagged");
  a_mark_ticks:
    assert property (clk_en && mark_f_d != mark_f_q |=> tick_q)
    else $error("timing mark edge gave no subscan pulse");
  a_dummy_len:
    assert property (state_q == bpss_pkg::BPSS_EVEN &&
                     $past(state_q) == bpss_pkg::BPSS_DUMMY |->
                     dcnt_q >= 5'(DUMMY_SS))
    else $error("even phase began before dummy subscans ended");
  a_parity_walk:
    assert property (cmp_v_q && state_q != bpss_pkg::BPSS_IDLE |->
                     cmp_pos_q[0] == par_q)
    else $error("examined position of wrong parity");
  a_print_once:
    assert property ((hit_q & printed_q) == '0 && (hit_q & ~req_q) == '0)
    else $error("match on printed or unrequested position");
  a_extra_end:
    assert property (clk_en && tick_q && !home_edge_q &&
                     state_q == bpss_pkg::BPSS_EXTRA &&
                     ss_q == bpss_pkg::SS_LAST |=> line_done_q && !line_busy_q)
    else $error("extra scan did not close the line");
  a_scan_count:
    assert property (cnt_q < n_chars)
    else $error("print scan count exceeds set size");

endmodule

//--- bpss_pkg.sv
/*
  Constants shared by the belt print scan sequencer: print geometry, subscan
  layout, phase encoding and the character set sizes.
  Assumes a 132-position print line served by 66 hammers.
*/
package bpss_pkg;

  // ---------------------------------------------------------------
  // Print geometry
  // ---------------------------------------------------------------
  localparam int unsigned NUM_POS   = 132;
  localparam int unsigned NUM_HAM   = 66;
  localparam int unsigned POS_W     = 8;
  localparam int unsigned CHAR_W    = 7;
  localparam int unsigned NUM_SS    = 5;
  localparam int unsigned POS_STEP  = 10;
  localparam int unsigned BELT_STEP = 4;
  localparam int unsigned PER_SS    = 13;
  localparam int unsigned DUMMY_SS  = 18;
  localparam int unsigned MAX_FIRE  = 5;

  localparam logic [2:0] SS_FIRST = 3'h0;
  localparam logic [2:0] SS_LAST  = 3'h4;
  localparam logic [3:0] K_LAST   = 4'hc;

  // Bit 0 is print position 1, an odd position.
  localparam logic [NUM_POS-1:0] ODD_MASK = {66{2'b01}};

  // ---------------------------------------------------------------
  // Character set sizes
  // ---------------------------------------------------------------
  localparam logic [1:0] SET_48 = 2'h0;
  localparam logic [1:0] SET_64 = 2'h1;
  localparam logic [1:0] SET_96 = 2'h2;
  localparam logic [6:0] N_48   = 7'h30;
  localparam logic [6:0] N_64   = 7'h40;
  localparam logic [6:0] N_96   = 7'h60;

  // ---------------------------------------------------------------
  // Line phases, Gray coded along the usual path from idle to extra
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    BPSS_IDLE  = 3'b000,
    BPSS_ODD   = 3'b001,
    BPSS_DUMMY = 3'b011,
    BPSS_EVEN  = 3'b010,
    BPSS_EXTRA = 3'b110
  } bpss_state_t;

endpackage

//--- bpss_img_mem.sv
/*
  Print image memory: one requested character code per print position,
  with a registered read port.
  Assumes writer and reader share clk_sys; a write and a read of the same
  word in one cycle return the old word.
*/
`timescale 1ns/100ps

module bpss_img_mem #(
  parameter int unsigned WIDTH = 7,
  parameter int unsigned DEPTH = 132,
  parameter int unsigned AW    = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             clk_en,
  input  wire logic             wr_en,
  input  wire logic [AW-1:0]    wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data_q
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      if (wr_en && (wr_addr < AW'(DEPTH))) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data_q <= mem_q[rd_addr];
    end
  end

endmodule

//--- bpss_belt_model.sv
/*
  Type belt transducer model for the scan sequencer bench: raised timing
  marks, home pulses and a running subscan index for the hammer monitor.
  Assumes clk_sys is the sequencer's clock and the belt never stops.
*/
`timescale 1ns/100ps

module bpss_belt_model #(
  parameter int unsigned SUB_CYC = 20
) (
  input  wire logic       clk_sys,
  input  wire logic [6:0] n_chars,
  input  wire logic       bad_home,
  output logic            timing_mark,
  output logic            home_mark,
  output logic            mid_sub,
  output logic [8:0]      sub_idx
);
  // ---------------------------------------------------------------
  // Belt motion
  // ---------------------------------------------------------------
  logic [4:0] cyc_q;
  logic [8:0] last_idx;

  assign last_idx = 9'(n_chars) * 9'h5 - 9'h1;
  assign mid_sub  = (cyc_q == 5'(SUB_CYC / 2));

  initial begin
    cyc_q = 5'h0;
    timing_mark = 1'b0;
    sub_idx = 9'h0;
  end

  always @(posedge clk_sys) begin
    cyc_q <= (cyc_q == 5'(SUB_CYC - 1)) ? 5'h0 : cyc_q + 5'h1;
    if (cyc_q == 5'(SUB_CYC - 1)) begin
      // Both edges of a mark count, so one mark gives two subscans.
      timing_mark <= ~timing_mark;
      sub_idx     <= (sub_idx >= last_idx) ? 9'h0 : sub_idx + 9'h1;
    end
  end

  // Home comes one subscan before the set start, so index 0 follows it.
  // A misplaced home is sent only while the bench asks for one.
  assign home_mark = (cyc_q >= 5'(SUB_CYC / 2)) &&
                     (cyc_q < 5'(SUB_CYC / 2 + 6)) &&
                     ((sub_idx == last_idx) ||
                      (bad_home && sub_idx == 9'h2));
endmodule

//--- belt_print_scan_sequencer_test.sv
/*
  Self-checking bench for the belt print scan sequencer: lines in all set
  sizes, hammer overflow and a misplaced home pulse.
  Assumes the belt model gives 20-cycle subscans at a 10 MHz clk_sys.
*/
`timescale 1ns/100ps

module belt_print_scan_sequencer_test;
  localparam int SUB = 20;
  logic        clk_sys, rst_n, clk_en, start_line, img_we, img_print;
  logic        bad_home, timing_mark, home_mark, mid_sub;
  logic        line_busy_q, line_done_q, belt_synced_q, sync_err_q;
  logic [1:0]  charset_sel;
  logic [7:0]  img_addr;
  logic [6:0]  img_char, n_chars;
  logic [8:0]  sub_idx;
  logic [65:0] hammer_fire_q;
  logic        req [132];
  logic        hit [132];
  logic [6:0]  chr [132];
  int          n_mismatch, checks, cyc, nsub, lo, fe;

  bpss_sequencer i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .timing_mark(timing_mark), .home_mark(home_mark),
    .charset_sel(charset_sel), .start_line(start_line), .img_we(img_we),
    .img_addr(img_addr), .img_char(img_char), .img_print(img_print),
    .hammer_fire_q(hammer_fire_q), .line_busy_q(line_busy_q),
    .line_done_q(line_done_q), .belt_synced_q(belt_synced_q),
    .sync_err_q(sync_err_q));

  bpss_belt_model #(.SUB_CYC(SUB)) i_belt (.clk_sys(clk_sys),
    .n_chars(n_chars), .bad_home(bad_home), .timing_mark(timing_mark),
    .home_mark(home_mark), .mid_sub(mid_sub), .sub_idx(sub_idx));

  // ---------------------------------------------------------------
  // Checking and closing
  // ---------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // ---------------------------------------------------------------
  // Hammer monitor
  // ---------------------------------------------------------------
  // Mid-subscan, the hammers shown belong to the previous subscan's compare,
  // whose aligned character follows from the belt index alone.
  always @(posedge clk_sys) begin : monitor
    int   prev, nfire;
    logic ok;
    if (mid_sub && rst_n) begin
      nsub++;
      prev = (sub_idx == 0) ? 5 * n_chars - 1 : sub_idx - 1;
      nfire = 0;
      for (int h = 0; h < 66; h++) begin
        if (hammer_fire_q[h] !== 1'b0) begin
          nfire++;
          ok = 1'b0;
          for (int q = 2 * h; q < 2 * h + 2; q++) begin
            if (req[q] && !hit[q] && !ok && (q % 10) / 2 == prev % 5 &&
                (prev / 5 + prev % 5 + 4 * (q / 10)) % n_chars == chr[q]) begin
              ok = 1'b1;
              hit[q] = 1'b1;
              if (q % 2 == 0) lo = nsub;
              else if (fe < 0) fe = nsub;
            end
          end
          chk("hammer_fire_q", 1, ok);
        end
      end
      chk("fires_per_subscan", 1, nfire <= bpss_pkg::MAX_FIRE);
    end
  end

  // ---------------------------------------------------------------
  // Drivers
  // ---------------------------------------------------------------
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  function automatic logic flag(input int w);
    case (w)
      0: return belt_synced_q;
      1: return line_done_q;
      default: return sync_err_q;
    endcase
  endfunction

  task automatic wait_hi(input int w, input int lim);
    int i;
    i = 0;
    while (flag(w) !== 1'b1 && i < lim) begin
      @(negedge clk_sys);
      i++;
    end
  endtask

  // The write strobe stays high between words; wr_end lowers it.
  task automatic wr(input int p, input int c, input logic pr);
    @(posedge clk_sys);
    img_we <= 1'b1;
    img_addr <= 8'(p);
    img_char <= 7'(c);
    img_print <= pr;
    req[p] = pr;
    chr[p] = 7'(c);
    hit[p] = 1'b0;
  endtask

  task automatic wr_end;
    @(posedge clk_sys);
    img_we <= 1'b0;
  endtask

  task automatic pulse_start;
    @(posedge clk_sys);
    start_line <= 1'b1;
    @(posedge clk_sys);
    start_line <= 1'b0;
  endtask

  task automatic restart(input logic [1:0] sel, input logic [6:0] n);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    charset_sel <= sel;
    n_chars <= n;
    ticks(10);
    chk("outputs_in_reset", 0, {hammer_fire_q, line_busy_q, line_done_q,
                                belt_synced_q, sync_err_q} != 0);
    rst_n <= 1'b1;
    wait_hi(0, (5 * n + 4) * SUB);
    chk("belt_synced_q", 1, belt_synced_q);
    for (int p = 0; p < 132; p++) wr(p, 0, 1'b0);
    wr_end;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Each request is placed to align on belt scan b0 + i, so a line that
  // stops early is far shorter than one running all its scans.
  task automatic run_line(input logic [1:0] sel, input logic [6:0] n);
    int p [8] = '{0, 1, 9, 19, 65, 128, 130, 131};
    int t0, b0, c;
    restart(sel, n);
    // Load during subscan one of a scan, so the line opens on belt scan b0.
    while (!(mid_sub && sub_idx % 5 == 0)) @(negedge clk_sys);
    b0 = (sub_idx / 5 + 1) % n;
    foreach (p[i]) begin
      c = ((p[i] % 10) / 2 + 4 * (p[i] / 10) + i + b0) % n;
      wr(p[i], c, 1);
    end
    wr_end;
    lo = 0;
    fe = -1;
    pulse_start;
    t0 = cyc;
    wait_hi(1, (10 * n + 40) * SUB);
    chk("line_done_q", 1, line_done_q);
    chk("line_length", 1, cyc - t0 < (5 * n + 100) * SUB);
    chk("odd_even_gap", 1, fe - lo >= 19);
    foreach (p[i]) chk("printed", 1, hit[p[i]]);
    ticks(SUB);
    chk("line_busy_q", 0, line_busy_q);
    chk("hammers_idle", 0, hammer_fire_q != 0);
  endtask

  // Six hits in one subscan recur on every restart, so nothing prints.
  task automatic overflow;
    restart(bpss_pkg::SET_48, bpss_pkg::N_48);
    for (int k = 0; k < 6; k++) wr(10 * k, (4 * k + 5) % 48, 1);
    wr_end;
    pulse_start;
    ticks(300 * SUB);
    chk("line_busy_q", 1, line_busy_q);
    for (int k = 0; k < 6; k++) chk("not_printed", 0, hit[10 * k]);
  endtask

  task automatic sync_fault;
    restart(bpss_pkg::SET_48, bpss_pkg::N_48);
    @(posedge clk_sys);
    bad_home <= 1'b1;
    wait_hi(2, 250 * SUB);
    chk("sync_err_q", 1, sync_err_q);
    @(posedge clk_sys);
    bad_home <= 1'b0;
    pulse_start;
    ticks(2);
    chk("sync_err_q", 0, sync_err_q);
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    start_line = 1'b0;
    img_we = 1'b0;
    img_addr = 8'h00;
    img_char = 7'h00;
    img_print = 1'b0;
    bad_home = 1'b0;
    charset_sel = bpss_pkg::SET_48;
    n_chars = bpss_pkg::N_48;
    n_mismatch = 0;
    checks = 0;
    cyc = 0;
    nsub = 0;
    foreach (req[i]) req[i] = 1'b0;
    run_line(bpss_pkg::SET_48, bpss_pkg::N_48);
    run_line(bpss_pkg::SET_64, bpss_pkg::N_64);
    run_line(bpss_pkg::SET_96, bpss_pkg::N_96);
    overflow;
    sync_fault;
    wrap_up;
  end
endmodule
